// ### hdl/dma_channel_status_priority.sv
// Four-channel status, fault cause and priority arbitration logic
`timescale 1ns/1ps

// Contract
// R01: Any signalled error on a channel sets its fault flag.
// R02: While fault flag is set, cause register holds the five-bit error code.
// R03: Clearing the fault flag also returns the cause to no-error.
// R04: Running flag set at start, cleared at termination, untouched by writes. The code ignores a start while op_done_r is set.
// R05: Falling edge on peripheral control line sets the fall-seen flag.
// R06: Peripheral control line is treated as active low.
// R07: Status bit 0 shows the line's present level; writes ignored.
// R08: Software writes zero to reserved status bit 2.
// R09: Cause register read-only; codes none, config, timing, external and software abort.
// R10: Address, count, bus errors coded 001rr, 011rr, 010rr with source bits.
// R11: Channel priority is a two-bit field, level 3 highest.
// R12: Among simultaneous DMA requests the highest-priority channel is served first.
// R13: The same priority picks which pending interrupt is serviced first.
// R14: Ties at the top priority level are resolved round-robin.
// R15: Software should give channels 0 and 1 equal priority.
// R16: Status flags clear on write-one per bit and on reset.
// R17: Interrupt requested only if enabled and done, block done or enabled fall flag.
// R18: Acknowledge returns normal vector, or fault vector when fault flag set.
// R19: Reserved upper bits of cause and priority read zero, ignore writes.
module dma_channel_status_priority (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] start_evt,
  input wire logic [3:0] term_evt,
  input wire logic [3:0] block_evt,
  input wire logic [3:0] fault_evt,
  input wire logic [3:0][2:0] fault_kind,
  input wire logic [3:0][1:0] fault_src,
  input wire logic [3:0] periph_control_line_n,
  input wire logic [3:0] irq_allow,
  input wire logic [3:0] pcl_irq_en,
  input wire logic [3:0] dma_req,
  output logic [3:0] dma_grant,
  input wire logic iack,
  input wire logic [3:0][7:0] normal_vector_reg,
  input wire logic [3:0][7:0] fault_vector_reg,
  output logic irq_req,
  output logic [7:0] vec_out,
  output logic vec_valid,
  output logic [1:0] vec_ch,
  output logic [3:0] channel_running
);

  // Highest requesting rank, then first such channel after the last winner
  function automatic logic [2:0] pick(input logic [3:0] req, input logic [3:0][1:0] rk,
                                      input logic [1:0] last);
    logic [1:0] best;
    logic [1:0] c;
    logic found;
    logic [1:0] idx;
    best = 2'h0;
    found = 1'b0;
    idx = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (req[i] && rk[i] > best) begin
        best = rk[i]; // R11
      end
    end
    for (int k = 1; k <= 4; k++) begin
      c = 2'(last + 2'(k)); // R14
      if (!found && req[c] && rk[c] == best) begin
        found = 1'b1; // R12
        idx = c;
      end
    end
    return {found, idx};
  endfunction : pick

  function automatic logic [4:0] encode(input logic [2:0] kind, input logic [1:0] src);
    logic [4:0] code;
    code = dma_stat_pkg::FC_CONFIG;
    unique case (dma_stat_pkg::fault_kind_e'(kind))
      dma_stat_pkg::FK_CONFIG: code = dma_stat_pkg::FC_CONFIG; // R09
      dma_stat_pkg::FK_TIMING: code = dma_stat_pkg::FC_TIMING; // R09
      dma_stat_pkg::FK_ADDR: code = {dma_stat_pkg::FC_ADDR_HI, src}; // R10
      dma_stat_pkg::FK_COUNT: code = {dma_stat_pkg::FC_COUNT_HI, src}; // R10
      dma_stat_pkg::FK_BUS: code = {dma_stat_pkg::FC_BUS_HI, src}; // R10
      dma_stat_pkg::FK_EXT_ABORT: code = dma_stat_pkg::FC_EXT_ABORT; // R09
      dma_stat_pkg::FK_SW_ABORT: code = dma_stat_pkg::FC_SW_ABORT; // R09
      // Unused kind code falls back to a configuration fault
      default: code = dma_stat_pkg::FC_CONFIG;
    endcase
    return code;
  endfunction : encode

  logic [3:0] op_done_r, op_done_nxt;
  logic [3:0] block_done_r, block_done_nxt;
  logic [3:0] fault_r, fault_nxt;
  logic [3:0] running_r, running_nxt;
  logic [3:0] fall_r, fall_nxt;
  logic [3:0] level_r, level_nxt;
  logic [3:0][4:0] cause_r, cause_nxt;
  logic [3:0][1:0] rank_r, rank_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [3:0] grant_r, grant_nxt;
  logic [1:0] dma_last_r, dma_last_nxt;
  logic [1:0] irq_last_r, irq_last_nxt;
  logic irq_r, irq_nxt;
  logic [7:0] vec_r, vec_nxt;
  logic vec_valid_r, vec_valid_nxt;
  logic [1:0] vec_ch_r, vec_ch_nxt;
  logic [1:0] wr_ch;
  logic [5:0] wr_off;
  logic [3:0] irq_pend;
  logic [2:0] dma_pick;
  logic [2:0] irq_pick;

  assign wr_ch = reg_addr[7:dma_stat_pkg::CH_SEL_LSB];
  assign wr_off = reg_addr[dma_stat_pkg::CH_SEL_LSB-1:0];
  assign dma_pick = pick(dma_req, rank_r, dma_last_r);
  assign irq_pick = pick(irq_pend, rank_r, irq_last_r);

  always_comb begin
    logic csr_wr;
    csr_wr = 1'b0;
    op_done_nxt = op_done_r;
    block_done_nxt = block_done_r;
    fault_nxt = fault_r;
    running_nxt = running_r;
    fall_nxt = fall_r;
    cause_nxt = cause_r;
    rank_nxt = rank_r;
    // Present line level; low active line is reported raw, 0 = low
    level_nxt = periph_control_line_n; // R06 R07
    for (int ch = 0; ch < 4; ch++) begin
      csr_wr = reg_wr && wr_ch == 2'(ch) && wr_off == dma_stat_pkg::CSR_OFF;
      // Write-one clears; a same-cycle hardware set wins over the clear
      if (csr_wr) begin
        op_done_nxt[ch] = op_done_r[ch] & ~reg_wdata[dma_stat_pkg::CSR_OP_DONE_BIT]; // R16
        block_done_nxt[ch] = block_done_r[ch] & ~reg_wdata[dma_stat_pkg::CSR_BLOCK_DONE_BIT]; // R16
        fall_nxt[ch] = fall_r[ch] & ~reg_wdata[dma_stat_pkg::CSR_FALL_BIT]; // R16
        if (reg_wdata[dma_stat_pkg::CSR_FAULT_BIT]) begin
          fault_nxt[ch] = 1'b0; // R16
          cause_nxt[ch] = dma_stat_pkg::FC_NONE; // R03
        end
      end
      // Falling edge of the active-low line means the peripheral asserted it
      if (level_r[ch] && !periph_control_line_n[ch]) begin
        fall_nxt[ch] = 1'b1; // R05 R06
      end
      // Keep the first cause until software clears the flag
      if (fault_evt[ch]) begin
        fault_nxt[ch] = 1'b1; // R01
        if (!fault_nxt[ch] || !fault_r[ch] || cause_nxt[ch] == dma_stat_pkg::FC_NONE) begin
          cause_nxt[ch] = encode(fault_kind[ch], fault_src[ch]); // R02
        end
      end
      if (block_evt[ch]) begin
        block_done_nxt[ch] = 1'b1;
      end
      // A new start is refused until the previous completion is cleared
      if (start_evt[ch] && !op_done_r[ch]) begin
        running_nxt[ch] = 1'b1; // R04
      end
      if (term_evt[ch] && running_r[ch]) begin
        running_nxt[ch] = 1'b0; // R04
        op_done_nxt[ch] = 1'b1;
      end
      if (reg_wr && wr_ch == 2'(ch) && wr_off == dma_stat_pkg::CPR_OFF) begin
        rank_nxt[ch] = reg_wdata[1:0]; // R11 R19
      end
    end
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      unique case (wr_off)
        // Bit 2 reserved and bit 5 unused: both read zero
        dma_stat_pkg::CSR_OFF: rdata_nxt = {op_done_r[wr_ch], block_done_r[wr_ch], 1'b0, fault_r[wr_ch],
                                            running_r[wr_ch], 1'b0, fall_r[wr_ch], level_r[wr_ch]}; // R07 R08
        dma_stat_pkg::CER_OFF: rdata_nxt = {3'h0, cause_r[wr_ch]}; // R09 R19
        dma_stat_pkg::CPR_OFF: rdata_nxt = {6'h00, rank_r[wr_ch]}; // R11 R19
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_comb begin
    irq_pend = irq_allow & (op_done_r | block_done_r | (fall_r & pcl_irq_en)); // R17
    grant_nxt = 4'h0;
    dma_last_nxt = dma_last_r;
    irq_last_nxt = irq_last_r;
    vec_nxt = vec_r;
    vec_ch_nxt = vec_ch_r;
    vec_valid_nxt = 1'b0;
    irq_nxt = |irq_pend; // R17
    if (dma_pick[2]) begin
      grant_nxt[dma_pick[1:0]] = 1'b1; // R12 R14
      dma_last_nxt = dma_pick[1:0];
    end
    // Acknowledge with nothing pending is ignored and returns no vector
    if (iack && irq_pick[2]) begin
      vec_valid_nxt = 1'b1; // R13
      vec_ch_nxt = irq_pick[1:0];
      irq_last_nxt = irq_pick[1:0];
      vec_nxt = fault_r[irq_pick[1:0]] ? fault_vector_reg[irq_pick[1:0]]
                                       : normal_vector_reg[irq_pick[1:0]]; // R18
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op_done_r <= 4'h0;
      block_done_r <= 4'h0;
      fault_r <= 4'h0;
      running_r <= 4'h0;
      fall_r <= 4'h0;
      // Assume an idle (high) line so reset does not fake a falling edge
      level_r <= dma_stat_pkg::LEVEL_RST;
      cause_r <= {4{dma_stat_pkg::FC_NONE}};
      rank_r <= {4{dma_stat_pkg::RANK_RST}};
      rdata_r <= dma_stat_pkg::RDATA_RST;
      grant_r <= 4'h0;
      dma_last_r <= dma_stat_pkg::LAST_RST;
      irq_last_r <= dma_stat_pkg::LAST_RST;
      irq_r <= 1'b0;
      vec_r <= 8'h00;
      vec_valid_r <= 1'b0;
      vec_ch_r <= 2'h0;
    end else begin
      op_done_r <= op_done_nxt;
      block_done_r <= block_done_nxt;
      fault_r <= fault_nxt;
      running_r <= running_nxt;
      fall_r <= fall_nxt;
      level_r <= level_nxt;
      cause_r <= cause_nxt;
      rank_r <= rank_nxt;
      rdata_r <= rdata_nxt;
      grant_r <= grant_nxt;
      dma_last_r <= dma_last_nxt;
      irq_last_r <= irq_last_nxt;
      irq_r <= irq_nxt;
      vec_r <= vec_nxt;
      vec_valid_r <= vec_valid_nxt;
      vec_ch_r <= vec_ch_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign dma_grant = grant_r;
  assign irq_req = irq_r;
  assign vec_out = vec_r;
  assign vec_valid = vec_valid_r;
  assign vec_ch = vec_ch_r;
  assign channel_running = running_r;

  // Assertion helpers
  logic [3:0] cause_set;
  logic [1:0] g_idx;
  logic grant_top_ok;
  logic [7:0] ack_vec;
  always_comb begin
    g_idx = 2'h0;
    ack_vec = fault_r[irq_pick[1:0]] ? fault_vector_reg[irq_pick[1:0]] : normal_vector_reg[irq_pick[1:0]];
    for (int i = 0; i < 4; i++) begin
      cause_set[i] = cause_r[i] != dma_stat_pkg::FC_NONE;
      if (grant_r[i]) begin
        g_idx = 2'(i);
      end
    end
  end
  assign grant_top_ok = rank_r[g_idx] == dma_stat_pkg::RANK_TOP;

  property p_fault_set;
    @(posedge clk) disable iff (!rstn) fault_evt[3] |=> fault_r[3];
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault flag not set by error"); // R01

  property p_cause_match;
    @(posedge clk) disable iff (!rstn) cause_set == fault_r;
  endproperty
  a_cause_match: assert property (p_cause_match) else $error("cause and fault flag disagree"); // R02

  property p_cause_clear;
    @(posedge clk) disable iff (!rstn)
      reg_wr && reg_addr == 8'hc0 && reg_wdata[4] && !fault_evt[3] |=> cause_r[3] == 5'h00;
  endproperty
  a_cause_clear: assert property (p_cause_clear) else $error("cause not cleared"); // R03

  property p_run_write;
    @(posedge clk) disable iff (!rstn) reg_wr && start_evt == 4'h0 && term_evt == 4'h0 |=> $stable(running_r);
  endproperty
  a_run_write: assert property (p_run_write) else $error("write changed running flag"); // R04

  property p_fall;
    @(posedge clk) disable iff (!rstn) level_r[0] && !periph_control_line_n[0] |=> fall_r[0];
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed"); // R05

  property p_level;
    @(posedge clk) disable iff (!rstn) ##1 level_r == $past(periph_control_line_n);
  endproperty
  a_level: assert property (p_level) else $error("level bit stale"); // R07

  property p_top_rank;
    @(posedge clk) disable iff (!rstn)
      dma_req == 4'hf && rank_r[2] == 2'h3 && $stable(rank_r) |=> grant_top_ok;
  endproperty
  a_top_rank: assert property (p_top_rank) else $error("lower rank granted over top"); // R12

  property p_round_robin;
    @(posedge clk) disable iff (!rstn)
      dma_req == 4'h3 && rank_r[0] == rank_r[1] && $stable(rank_r) ##1 dma_req == 4'h3
      |=> grant_r != $past(grant_r);
  endproperty
  a_round_robin: assert property (p_round_robin) else $error("tie not rotated"); // R14

  property p_irq;
    @(posedge clk) disable iff (!rstn) ##1 irq_r == |$past(irq_pend);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request wrong"); // R17

  property p_vector;
    @(posedge clk) disable iff (!rstn) vec_valid_r |-> vec_r == $past(ack_vec);
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector returned"); // R18

  property p_reserved;
    @(posedge clk) disable iff (!rstn) reg_rd && reg_addr[5:0] != 6'h00 |=> reg_rdata[7:5] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // R19

  c_fault: cover property (@(posedge clk) disable iff (!rstn) fault_evt[3] ##1 fault_r[3] ##[1:20] !fault_r[3]);
  c_tie: cover property (@(posedge clk) disable iff (!rstn) grant_r == 4'h1 ##1 grant_r == 4'h2);
  c_ack: cover property (@(posedge clk) disable iff (!rstn) vec_valid_r && fault_r[vec_ch_r]);
endmodule : dma_channel_status_priority

// ### include/dma_stat_pkg.sv
// Shared constants and types for the DMA channel status and priority block
package dma_stat_pkg;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned OFF_W = 6;
  // Channel number sits above the register offset in the address
  localparam int unsigned CH_SEL_LSB = 6;
  localparam logic [5:0] CSR_OFF = 6'h00;
  localparam logic [5:0] CER_OFF = 6'h01;
  localparam logic [5:0] CPR_OFF = 6'h2d;
  localparam int unsigned CSR_OP_DONE_BIT = 7;
  localparam int unsigned CSR_BLOCK_DONE_BIT = 6;
  localparam int unsigned CSR_FAULT_BIT = 4;
  localparam int unsigned CSR_FALL_BIT = 1;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [1:0] RANK_RST = 2'h0;
  localparam logic [1:0] RANK_TOP = 2'h3;
  // Idle line is high, so the level bits start high to avoid a false fall
  localparam logic [3:0] LEVEL_RST = 4'hf;
  // Pointer starts on the last channel so channel 0 wins the first tie
  localparam logic [1:0] LAST_RST = 2'h3;
  localparam logic [4:0] FC_NONE = 5'h00;
  localparam logic [4:0] FC_CONFIG = 5'h01;
  localparam logic [4:0] FC_TIMING = 5'h02;
  localparam logic [4:0] FC_RESERVED = 5'h03;
  localparam logic [4:0] FC_EXT_ABORT = 5'h10;
  localparam logic [4:0] FC_SW_ABORT = 5'h11;
  localparam logic [2:0] FC_ADDR_HI = 3'h1;
  localparam logic [2:0] FC_COUNT_HI = 3'h3;
  localparam logic [2:0] FC_BUS_HI = 3'h2;
  localparam logic [1:0] SRC_MEM = 2'h1;
  localparam logic [1:0] SRC_DEV = 2'h2;
  localparam logic [1:0] SRC_BASE = 2'h3;
  typedef enum logic [2:0] {
    FK_CONFIG = 3'h0,
    FK_TIMING = 3'h1,
    FK_ADDR = 3'h2,
    FK_COUNT = 3'h3,
    FK_BUS = 3'h4,
    FK_EXT_ABORT = 3'h5,
    FK_SW_ABORT = 3'h6
  } fault_kind_e;
endpackage : dma_stat_pkg

// ### testbench/host_bus_model.sv
// Host processor model driving the register bus of the status block
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // Idle bus shows inverted values so stale data never looks valid
  task automatic cycle(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = ~w;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cycle(a, (a[5:0] == dma_stat_pkg::CSR_OFF) ? (d & 8'hfb) : d, 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    cycle(a, 8'h00, 1'b0);
  endtask : rd
endmodule : host_bus_model

// ### testbench/tb_dma_channel_status_priority.sv
// Self-checking bench for the DMA channel status and priority block
`timescale 1ns/1ps
module tb_dma_channel_status_priority;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, vec_out;
  logic reg_wr, reg_rd, irq_req, vec_valid;
  logic [3:0] start_evt = 4'h0, term_evt = 4'h0, block_evt = 4'h0, fault_evt = 4'h0;
  logic [3:0][2:0] fault_kind = '0;
  logic [3:0][1:0] fault_src = '0;
  logic [3:0] periph_control_line_n = 4'hf, irq_allow = 4'h0, pcl_irq_en = 4'h0, dma_req = 4'h0;
  logic [3:0] dma_grant, channel_running;
  logic iack = 1'b0;
  logic [3:0][7:0] nvec = '0, fvec = '0;
  logic [1:0] vec_ch;
  logic [1:0] rd_q = 2'h0;
  logic [15:0] exp_rd[$], exp_gnt[$], exp_vec[$];
  logic [7:0] rank_w[4] = '{8'hfd, 8'h01, 8'hff, 8'hfc};
  logic [4:0] code;
  int miscompares = 0;
  int checks = 0;
  always #2.5 clk = ~clk;
  host_bus_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  dma_channel_status_priority DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .start_evt(start_evt), .term_evt(term_evt),
    .block_evt(block_evt), .fault_evt(fault_evt), .fault_kind(fault_kind), .fault_src(fault_src),
    .periph_control_line_n(periph_control_line_n), .irq_allow(irq_allow), .pcl_irq_en(pcl_irq_en),
    .dma_req(dma_req), .dma_grant(dma_grant), .iack(iack), .normal_vector_reg(nvec),
    .fault_vector_reg(fvec), .irq_req(irq_req), .vec_out(vec_out), .vec_valid(vec_valid), .vec_ch(vec_ch),
    .channel_running(channel_running));
  function automatic logic [7:0] channel_state_reg(input int c);
    return {2'(c), dma_stat_pkg::CSR_OFF};
  endfunction : channel_state_reg
  function automatic logic [7:0] fault_cause_reg(input int c);
    return {2'(c), dma_stat_pkg::CER_OFF};
  endfunction : fault_cause_reg
  function automatic logic [7:0] channel_rank_reg(input int c);
    return {2'(c), dma_stat_pkg::CPR_OFF};
  endfunction : channel_rank_reg
  function automatic logic [4:0] cause(input logic [2:0] k, input logic [1:0] s);
    case (k)
      3'h1: return dma_stat_pkg::FC_TIMING;
      3'h2: return {dma_stat_pkg::FC_ADDR_HI, s};
      3'h3: return {dma_stat_pkg::FC_COUNT_HI, s};
      3'h4: return {dma_stat_pkg::FC_BUS_HI, s};
      3'h5: return dma_stat_pkg::FC_EXT_ABORT;
      3'h6: return dma_stat_pkg::FC_SW_ABORT;
      default: return dma_stat_pkg::FC_CONFIG;
    endcase
  endfunction : cause
  // Empty queue gives unknown so an extra result always mismatches
  function automatic logic [15:0] pop(ref logic [15:0] q[$]);
    if (q.size() == 0) return 16'hxxxx;
    return q.pop_front();
  endfunction : pop
  task automatic chk(input logic [15:0] e, input logic [15:0] a);
    checks++;
    if (a !== e) begin
      miscompares++;
      $display("unexpected at %0t: expected %h got %h", $time, e, a);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_rd.push_back({8'h00, e});
    host.rd(a);
  endtask : rd_chk
  task automatic pulse(ref logic [3:0] sig, input logic [3:0] v);
    @(negedge clk);
    sig = v;
    @(negedge clk);
    sig = 4'h0;
  endtask : pulse
  task automatic hold_req(input logic [3:0] v, input int n);
    @(negedge clk);
    dma_req = v;
    repeat (n) @(negedge clk);
    dma_req = 4'h0;
  endtask : hold_req
  task automatic ack(input logic [15:0] e);
    exp_vec.push_back(e);
    @(negedge clk);
    iack = 1'b1;
    @(negedge clk);
    iack = 1'b0;
    repeat (2) @(negedge clk);
  endtask : ack
  // Read data is sampled one and a half cycles after the read edge, before the next read
  always @(posedge clk) rd_q <= {rd_q[0], reg_rd};
  always @(negedge clk) begin
    if (rd_q[1]) chk(pop(exp_rd), {8'h00, reg_rdata});
    if (dma_grant !== 4'h0) chk(pop(exp_gnt), {12'h000, dma_grant});
    if (vec_valid === 1'b1) chk(pop(exp_vec), {6'h00, vec_ch, vec_out});
  end
  initial begin
    #200000;
    miscompares++;
    test_done();
  end
  initial begin
    void'($urandom(52577));
    nvec = $urandom;
    fvec = $urandom;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    for (int c = 0; c < 4; c++) begin
      rd_chk(channel_state_reg(c), 8'h01);
      rd_chk(fault_cause_reg(c), 8'h00);
      rd_chk(channel_rank_reg(c), 8'h00);
    end
    rd_chk({2'h0, 6'h02}, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      fault_kind[3] = k[2:0];
      fault_src[3] = 2'h1 + 2'($urandom_range(2));
      code = cause(k[2:0], fault_src[3]);
      pulse(fault_evt, 4'h8);
      fault_kind[3] = 3'(k + 1);
      pulse(fault_evt, 4'h8);
      rd_chk(channel_state_reg(3), 8'h11);
      host.wr(fault_cause_reg(3), 8'hff);
      rd_chk(fault_cause_reg(3), {3'h0, code});
      host.wr(channel_state_reg(3), 8'h10);
      rd_chk(fault_cause_reg(3), 8'h00);
      rd_chk(channel_state_reg(3), 8'h01);
    end
    $display("test fault causes done");
    for (int c = 0; c < 4; c++) begin
      host.wr(channel_rank_reg(c), rank_w[c]);
      rd_chk(channel_rank_reg(c), {6'h00, rank_w[c][1:0]});
    end
    exp_gnt = '{16'h1, 16'h2, 16'h1, 16'h2, 16'h4, 16'h4, 16'h8};
    hold_req(4'h3, 4);
    hold_req(4'hf, 2);
    hold_req(4'h8, 1);
    repeat (3) @(negedge clk);
    chk(16'h0, 16'(exp_gnt.size()));
    $display("test arbitration done");
    pulse(start_evt, 4'h6);
    host.wr(channel_state_reg(1), 8'hff);
    chk({12'h0, channel_running}, 16'h6);
    pulse(term_evt, 4'h6);
    irq_allow = 4'h6;
    rd_chk(channel_state_reg(1), 8'h81);
    chk({12'h0, channel_running}, 16'h0);
    chk({15'h0, irq_req}, 16'h1);
    fault_kind[2] = 3'h6;
    pulse(fault_evt, 4'h4);
    ack({6'h0, 2'h2, fvec[2]});
    host.wr(channel_state_reg(2), 8'hff);
    ack({6'h0, 2'h1, nvec[1]});
    host.wr(channel_state_reg(1), 8'h80);
    repeat (2) @(negedge clk);
    chk({15'h0, irq_req}, 16'h0);
    $display("test running and vectors done");
    @(negedge clk);
    periph_control_line_n = 4'he;
    irq_allow = 4'h9;
    rd_chk(channel_state_reg(0), 8'h02);
    chk({15'h0, irq_req}, 16'h0);
    pcl_irq_en = 4'h1;
    periph_control_line_n = 4'hf;
    rd_chk(channel_state_reg(0), 8'h03);
    chk({15'h0, irq_req}, 16'h1);
    host.wr(channel_state_reg(0), 8'h03);
    rd_chk(channel_state_reg(0), 8'h01);
    pulse(block_evt, 4'h8);
    rd_chk(channel_state_reg(3), 8'h41);
    chk({15'h0, irq_req}, 16'h1);
    host.wr(channel_state_reg(3), 8'h40);
    rd_chk(channel_state_reg(3), 8'h01);
    chk({15'h0, irq_req}, 16'h0);
    repeat (4) @(negedge clk);
    chk(16'h0, 16'(exp_rd.size() + exp_vec.size()));
    $display("test line and block done");
    pulse(block_evt, 4'h1);
    @(negedge clk);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    rd_chk(channel_state_reg(0), 8'h01);
    rd_chk(channel_rank_reg(0), 8'h00);
    chk(16'h0, {15'h0, irq_req});
    repeat (3) @(negedge clk);
    chk(16'h0, 16'(exp_rd.size()));
    $display("test mid-run reset done");
    test_done();
  end
endmodule : tb_dma_channel_status_priority
